// ---- rtl/prfr_framer.sv ----
// Reader transmit framer: APB registers, frame checking and rate control
//
// Functional notes
// - NAD only in first chained block
// - RFU bits keep their default value
// - no field carries an RFU value
// - R-block carries no INF field
// - S(WTX) carries exactly one INF byte
// - S(PARAMETERS) any INF; other S none
// - PCB and first byte codings allowed
// - REQB PARAM b8-b6 are zero
// - REQB slot count not 101/110/111
// - ATTRIB Param 1 b2-b1 are zero
// - ATTRIB TR0 field never 11
// - ATTRIB TR1 field never 11
// - ATTRIB Param 2 nibble below nine
// - ATTRIB Param 3 b8-b4 are zero
// - Param 4 upper zero, nibble not F
// - RATS follows Type A activation
// - optional PPS within card capability
// - first block uses selected rate
// - selected rate applies both directions
// - next polling cycle returns to base
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "prfr_defines.svh"
module prfr_framer
    import prfr_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter int TICKS_BASE = `PRFR_TICKS_BASE
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              lclk_pin,
    output logic                   tx_out,
    output logic                   tx_active,
    output logic      [1:0]        rate_tx,
    output logic      [1:0]        rate_rx,
    output logic                   viol_any
);
    generate
        if (ADDR_W < 4 || ADDR_W > 32)
        begin : g_bad
            $error("prfr_framer: ADDR_W out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Declarations

    prfr_ser_if ser_if ();

    prfr_kind_t  kind_q;
    prfr_kind_t  fkind_q;
    prfr_state_t st_q;
    prfr_state_t st_d;
    logic [7:0]  cap_q;
    logic [7:0]  viol_q;
    logic [7:0]  pos_q;
    logic [7:0]  pcb_q;
    logic        chain_q;
    prfr_rate_t  rate_tx_q;
    prfr_rate_t  rate_rx_q;
    prfr_rate_t  pend_tx_q;
    prfr_rate_t  pend_rx_q;
    logic [31:0] prdata_q;

    wire logic        acc;
    wire logic        setup;
    wire logic        sel_ctrl;
    wire logic        sel_cap;
    wire logic        sel_tx;
    wire logic        sel_stat;
    wire logic        mapped;
    wire logic        tx_stall;
    wire logic        wr_en;
    wire logic        take;
    wire logic [31:0] rd_mux;
    wire logic        act_cmd;
    wire logic        poll_cmd;
    wire logic        pack_cmd;
    wire logic [7:0]  clr_v;
    wire logic [7:0]  set_v;

    wire logic [7:0]  b;
    wire logic        last;
    wire logic        first;
    prfr_kind_t       kind;
    wire logic        k_blk;
    wire logic        k_reqb;
    wire logic        k_att;
    wire logic        k_rats;
    wire logic        k_pps;
    wire logic [7:0]  pcb;
    wire logic        i_blk;
    wire logic        r_blk;
    wire logic        s_blk;
    wire logic        rfu_blk;
    wire logic        has_cid;
    wire logic        has_nad;
    wire logic [1:0]  s_type;
    wire logic        pcb_bad;
    wire logic [7:0]  prolog;
    wire logic [7:0]  inf_len;
    wire logic        at_end;
    wire logic [1:0]  dri;
    wire logic [1:0]  dsi;
    wire logic        dri_ok;
    wire logic        dsi_ok;
    wire logic        pps1_at;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    assign setup    = psel & ~penable;
    assign acc      = psel & penable;
    assign sel_ctrl = paddr == ADDR_W'(`PRFR_OFF_CTRL);
    assign sel_cap  = paddr == ADDR_W'(`PRFR_OFF_CAP);
    assign sel_tx   = paddr == ADDR_W'(`PRFR_OFF_TXDATA);
    assign sel_stat = paddr == ADDR_W'(`PRFR_OFF_STATUS);
    assign mapped   = sel_ctrl | sel_cap | sel_tx | sel_stat;
    // A byte write waits in the access phase while a character is on air
    assign tx_stall = acc & pwrite & sel_tx & ~ser_if.ready;
    assign pready   = ce & ~tx_stall;
    assign pslverr  = acc & ~mapped;
    assign wr_en    = acc & pwrite & pready & mapped;
    assign take     = wr_en & sel_tx;

    assign act_cmd  = wr_en & sel_ctrl & pwdata[`PRFR_CTRL_ACT_BIT];
    assign poll_cmd = wr_en & sel_ctrl & pwdata[`PRFR_CTRL_POLL_BIT];
    assign pack_cmd = wr_en & sel_ctrl & pwdata[`PRFR_CTRL_PACK_BIT];
    assign clr_v    = (wr_en & sel_stat) ? pwdata[7:0] : 8'h00;

    assign rd_mux = sel_ctrl ? {29'h0, kind_q} :
                    sel_cap  ? {24'h0, cap_q} :
                    sel_stat ? {16'h0, ser_if.busy, st_q,
                                rate_rx_q, rate_tx_q, viol_q} :
                    32'h0;

    assign prdata   = prdata_q;
    assign viol_any = |viol_q;
    assign rate_tx  = rate_tx_q;
    assign rate_rx  = rate_rx_q;

    ////////////////////////////////////////////////////////////////////
    // Byte stream decode

    assign b     = pwdata[7:0];
    assign last  = pwdata[`PRFR_TXD_LAST_BIT];
    assign first = pos_q == 8'h00;
    assign kind  = first ? kind_q : fkind_q;
    assign k_blk  = kind == PRFR_K_BLOCK;
    assign k_reqb = kind == PRFR_K_REQB;
    assign k_att  = kind == PRFR_K_ATTRIB;
    assign k_rats = kind == PRFR_K_RATS;
    assign k_pps  = kind == PRFR_K_PPS;

    assign pcb     = first ? b : pcb_q;
    assign i_blk   = pcb[7:6] == 2'b00;
    assign rfu_blk = pcb[7:6] == 2'b01;
    assign r_blk   = pcb[7:6] == 2'b10;
    assign s_blk   = pcb[7:6] == 2'b11;
    assign has_cid = pcb[3];
    assign has_nad = i_blk & pcb[2];
    assign s_type  = pcb[5:4];
    // Fixed bits of each block type
    assign pcb_bad = (i_blk & (pcb[5] | ~pcb[1])) |
                     (r_blk & (~pcb[5] | pcb[2] | ~pcb[1])) |
                     (s_blk & (pcb[2] | ~pcb[1] | pcb[0]));
    assign prolog  = 8'h01 + {7'h0, has_cid} + {7'h0, has_nad};
    assign inf_len = pos_q + 8'h01 - prolog;
    assign at_end  = take & k_blk & last;

    assign pps1_at = k_pps & (pos_q == 8'h02);
    assign dsi     = b[3:2];
    assign dri     = b[1:0];
    assign dri_ok  = (dri == 2'b00) | cap_q[dri - 2'b01];
    assign dsi_ok  = (dsi == 2'b00) | cap_q[3'(dsi) + 3'h3];

    ////////////////////////////////////////////////////////////////////
    // Violation detection

    assign set_v[`PRFR_V_NAD] = take & k_blk & first & chain_q &
                                has_nad;
    assign set_v[`PRFR_V_RFUBIT] = take & (
        (k_reqb & pos_q == 8'h02 & b[7:5] != 3'h0) |
        (k_att & pos_q == 8'h05 & b[1:0] != 2'h0) |
        (k_att & pos_q == 8'h07 & b[7:3] != 5'h00) |
        (k_att & pos_q == 8'h08 & b[7:4] != 4'h0) |
        (k_pps & pos_q == 8'h01 & b[7:5] != 3'h0) |
        (pps1_at & b[7:4] != 4'h0));
    assign set_v[`PRFR_V_RFUVAL] = take & (
        (k_blk & first & rfu_blk) |
        (k_blk & first & s_blk & s_type == 2'b01) |
        (k_reqb & pos_q == 8'h02 & b[2:0] > 3'h4) |
        (k_att & pos_q == 8'h05 & b[7:6] == 2'h3) |
        (k_att & pos_q == 8'h05 & b[5:4] == 2'h3) |
        (k_att & pos_q == 8'h06 & b[3:0] > 4'h8) |
        (k_att & pos_q == 8'h08 & b[3:0] == 4'hf));
    assign set_v[`PRFR_V_RLEN] = at_end & r_blk &
                                 inf_len != 8'h00;
    assign set_v[`PRFR_V_SLEN] = at_end & s_blk & (
        (s_type == `PRFR_S_WTX & inf_len != 8'h01) |
        (s_type == `PRFR_S_DESEL & inf_len != 8'h00));
    assign set_v[`PRFR_V_CODE] = take & (
        (k_blk & first & pcb_bad) |
        (k_reqb & first & b != `PRFR_CMD_REQB) |
        (k_att & first & b != `PRFR_CMD_ATTRIB) |
        (k_rats & first & b != `PRFR_CMD_RATS) |
        (k_pps & first & b[7:4] != `PRFR_CMD_PPS) |
        (k_pps & pos_q == 8'h01 & b[3:0] != `PRFR_PPS0_LOW));
    // RATS only right after activation; no block before RATS or PPS answer
    assign set_v[`PRFR_V_SEQ] = take & first & (
        (k_rats & st_q != PRFR_ST_ACT) |
        (k_pps & st_q != PRFR_ST_ATS) |
        (k_blk & (st_q == PRFR_ST_POLL | st_q == PRFR_ST_ACT)) |
        (k_blk & st_q == PRFR_ST_PPSW));
    assign set_v[`PRFR_V_PPS] = take & pps1_at & (
        ~dri_ok | ~dsi_ok | (cap_q[7] & dri != dsi));

    ////////////////////////////////////////////////////////////////////
    // Rate selection sequence

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            PRFR_ST_POLL:
            begin
                if (act_cmd)
                    st_d = PRFR_ST_ACT;
            end
            PRFR_ST_ACT:
            begin
                if (take & first & k_rats)
                    st_d = PRFR_ST_ATS;
            end
            PRFR_ST_ATS:
            begin
                if (take & first & k_pps)
                    st_d = PRFR_ST_PPSW;
                else if (take & first & k_blk)
                    st_d = PRFR_ST_SESS;
            end
            PRFR_ST_PPSW:
            begin
                if (pack_cmd)
                    st_d = PRFR_ST_SESS;
            end
            PRFR_ST_SESS:
            begin
                st_d = PRFR_ST_SESS;
            end
            default:
            begin
                st_d = PRFR_ST_POLL;
            end
        endcase
        if (poll_cmd)
            st_d = PRFR_ST_POLL;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kind_q   <= PRFR_K_BLOCK;
            cap_q    <= `PRFR_CAP_RST;
            prdata_q <= 32'h0;
        end
        else if (ce)
        begin
            if (wr_en & sel_ctrl)
                kind_q <= prfr_kind_t'(pwdata[2:0]);
            if (wr_en & sel_cap)
                cap_q <= pwdata[7:0];
            if (setup & ~pwrite)
                prdata_q <= rd_mux;
        end
    end

    // A set in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            viol_q <= `PRFR_VIOL_RST;
        else if (ce)
            viol_q <= (viol_q & ~clr_v) | set_v;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pos_q   <= 8'h00;
            fkind_q <= PRFR_K_BLOCK;
            pcb_q   <= 8'h00;
        end
        else if (ce & take)
        begin
            if (first)
            begin
                fkind_q <= kind_q;
                pcb_q   <= b;
            end
            if (last)
                pos_q <= 8'h00;
            else if (pos_q != 8'hff)
                pos_q <= pos_q + 8'h01;
        end
    end

    // Chaining is tracked on I-blocks only; R-blocks pass between them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chain_q <= 1'b0;
        else if (ce & poll_cmd)
            chain_q <= 1'b0;
        else if (ce & take & first & k_blk & i_blk)
            chain_q <= pcb[4];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q      <= PRFR_ST_POLL;
            rate_tx_q <= 2'b00;
            rate_rx_q <= 2'b00;
            pend_tx_q <= 2'b00;
            pend_rx_q <= 2'b00;
        end
        else if (ce)
        begin
            st_q <= st_d;
            if (take & first & k_pps)
            begin
                pend_tx_q <= 2'b00;
                pend_rx_q <= 2'b00;
            end
            else if (take & pps1_at)
            begin
                pend_tx_q <= dri;
                pend_rx_q <= dsi;
            end
            if (poll_cmd)
            begin
                rate_tx_q <= 2'b00;
                rate_rx_q <= 2'b00;
            end
            else if (pack_cmd & st_q == PRFR_ST_PPSW)
            begin
                rate_tx_q <= pend_tx_q;
                rate_rx_q <= pend_rx_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serialiser

    assign ser_if.valid = acc & pwrite & sel_tx & ce;
    assign ser_if.data  = b;
    assign ser_if.rate  = rate_tx_q;

    prfr_serial #(
        .TICKS_BASE (TICKS_BASE)
    ) u_serial (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .lclk_pin  (lclk_pin),
        .ser       (ser_if.snk),
        .tx_out    (tx_out),
        .tx_active (tx_active)
    );
endmodule // prfr_framer
`default_nettype wire

// ---- rtl/prfr_defines.svh ----
// Offsets, field positions, reset values and codes of the proximity framer
`ifndef PRFR_DEFINES_SVH
`define PRFR_DEFINES_SVH
`define PRFR_OFF_CTRL      8'h00
`define PRFR_OFF_CAP       8'h04
`define PRFR_OFF_TXDATA    8'h08
`define PRFR_OFF_STATUS    8'h0c
`define PRFR_CTRL_ACT_BIT  8
`define PRFR_CTRL_POLL_BIT 9
`define PRFR_CTRL_PACK_BIT 10
`define PRFR_TXD_LAST_BIT  8
`define PRFR_CAP_RST       8'h00
`define PRFR_VIOL_RST      8'h00
`define PRFR_V_NAD         0
`define PRFR_V_RFUBIT      1
`define PRFR_V_RFUVAL      2
`define PRFR_V_RLEN        3
`define PRFR_V_SLEN        4
`define PRFR_V_CODE        5
`define PRFR_V_SEQ         6
`define PRFR_V_PPS         7
`define PRFR_CMD_REQB      8'h05
`define PRFR_CMD_ATTRIB    8'h1d
`define PRFR_CMD_RATS      8'he0
`define PRFR_CMD_PPS       4'hd
`define PRFR_PPS0_LOW      4'h1
`define PRFR_S_DESEL       2'b00
`define PRFR_S_PARAM       2'b10
`define PRFR_S_WTX         2'b11
`define PRFR_TICKS_BASE    8
`endif

// ---- rtl/prfr_pkg.sv ----
// Types shared by the proximity framer modules
package prfr_pkg;
    typedef enum logic [2:0] {
        PRFR_K_BLOCK  = 3'b000,
        PRFR_K_REQB   = 3'b001,
        PRFR_K_ATTRIB = 3'b010,
        PRFR_K_RATS   = 3'b011,
        PRFR_K_PPS    = 3'b100,
        PRFR_K_RAW    = 3'b101
    } prfr_kind_t;
    typedef enum logic [2:0] {
        PRFR_ST_POLL = 3'b000,
        PRFR_ST_ACT  = 3'b001,
        PRFR_ST_ATS  = 3'b010,
        PRFR_ST_PPSW = 3'b011,
        PRFR_ST_SESS = 3'b100
    } prfr_state_t;
    typedef logic [1:0] prfr_rate_t;
endpackage

// ---- rtl/prfr_ser_if.sv ----
// Byte hand-over between the frame checker and the serialiser
`timescale 1ns/1ps
`default_nettype none
interface prfr_ser_if;
    logic                valid;
    logic                ready;
    logic [7:0]          data;
    prfr_pkg::prfr_rate_t rate;
    logic                busy;
    modport src (output valid, output data, output rate,
                 input ready, input busy);
    modport snk (input valid, input data, input rate,
                 output ready, output busy);
endinterface
`default_nettype wire

// ---- rtl/prfr_serial.sv ----
// Character serialiser paced by the sampled link clock
`timescale 1ns/1ps
`default_nettype none
`include "prfr_defines.svh"
module prfr_serial
    import prfr_pkg::*;
#(
    parameter int TICKS_BASE = `PRFR_TICKS_BASE
)(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic lclk_pin,
    prfr_ser_if.snk   ser,
    output logic      tx_out,
    output logic      tx_active
);
    generate
        if (TICKS_BASE < 8 || TICKS_BASE > 255)
        begin : g_bad
            $error("prfr_serial: TICKS_BASE out of range");
        end
    endgenerate

    logic       lclk_s1_q;
    logic       lclk_s2_q;
    logic       lclk_s3_q;
    logic [9:0] shift_q;
    logic [3:0] bits_q;
    logic [7:0] tick_q;
    logic [7:0] tick_max_q;
    wire logic  lclk_rise;
    wire logic  load;
    wire logic  step;

    assign lclk_rise = lclk_s2_q & ~lclk_s3_q;
    assign ser.busy  = bits_q != 4'h0;
    assign ser.ready = ~ser.busy;
    assign load      = ser.valid & ser.ready;
    assign step      = ser.busy & lclk_rise;
    assign tx_out    = shift_q[0];
    assign tx_active = ser.busy;

    // Higher rate shortens the bit to fewer link ticks, transmit direction only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_s1_q  <= 1'b0;
            lclk_s2_q  <= 1'b0;
            lclk_s3_q  <= 1'b0;
            shift_q    <= 10'h3ff;
            bits_q     <= 4'h0;
            tick_q     <= 8'h00;
            tick_max_q <= 8'h00;
        end
        else if (ce)
        begin
            lclk_s1_q <= lclk_pin;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            if (load)
            begin
                shift_q    <= {1'b1, ser.data, 1'b0};
                bits_q     <= 4'ha;
                tick_q     <= 8'h00;
                tick_max_q <= 8'(TICKS_BASE >> ser.rate) - 8'h01;
            end
            else if (step)
            begin
                if (tick_q == tick_max_q)
                begin
                    tick_q  <= 8'h00;
                    shift_q <= {1'b1, shift_q[9:1]};
                    bits_q  <= bits_q - 4'h1;
                end
                else
                begin
                    tick_q <= tick_q + 8'h01;
                end
            end
        end
    end
endmodule // prfr_serial
`default_nettype wire

// ---- tb/prfr_framer_checker.sv ----
// Port-level checker of the proximity reader framer
`timescale 1ns/1ps
`default_nettype none
`include "prfr_defines.svh"
module prfr_framer_checker
    import prfr_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter int TICKS_BASE = `PRFR_TICKS_BASE
)(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              lclk_pin,
    input wire logic              tx_out,
    input wire logic              tx_active,
    input wire logic [1:0]        rate_tx,
    input wire logic [1:0]        rate_rx,
    input wire logic              viol_any
);
    wire acc     = psel && penable && pready;
    wire mapped  = paddr == `PRFR_OFF_CTRL || paddr == `PRFR_OFF_CAP ||
                   paddr == `PRFR_OFF_TXDATA || paddr == `PRFR_OFF_STATUS;
    wire ctrl_wr = acc && pwrite && paddr == `PRFR_OFF_CTRL;
    wire stat_wr = acc && pwrite && paddr == `PRFR_OFF_STATUS;
    wire txd_wr  = acc && pwrite && paddr == `PRFR_OFF_TXDATA;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_byte_taken;
        txd_wr;
    endsequence
    sequence s_start_bit;
        tx_active && !tx_out;
    endsequence
    a_tx_start: assert property (s_byte_taken |=> s_start_bit)
        else $error("no start bit after byte accept");
    a_idle_high: assert property (!tx_active |-> tx_out)
        else $error("line not idle high");
    a_unmapped_err: assert property (psel && penable && !mapped
        |-> pslverr && pready == ce)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped
        |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_viol_sticky: assert property (viol_any && !stat_wr |=> viol_any)
        else $error("violation flag dropped");
    a_viol_cause: assert property ($rose(viol_any) |-> $past(txd_wr))
        else $error("violation without byte");
    a_rate_poll: assert property (ctrl_wr && pwdata[9]
        |=> rate_tx == 2'h0 && rate_rx == 2'h0)
        else $error("poll did not restore base rate");
    a_rate_cause: assert property (($changed(rate_tx) || $changed(rate_rx))
        |-> $past(ctrl_wr))
        else $error("rate changed without command");
    a_ce_freeze: assert property (!ce |-> !pready ##1 $stable(tx_out) &&
        $stable(viol_any) && $stable(rate_tx))
        else $error("state moved while clock enable low");
endmodule // prfr_framer_checker
bind prfr_framer prfr_framer_checker #(.ADDR_W(ADDR_W),
    .TICKS_BASE(TICKS_BASE)) chk_u (.pclk(pclk), .presetn(presetn),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lclk_pin(lclk_pin), .tx_out(tx_out),
    .tx_active(tx_active), .rate_tx(rate_tx), .rate_rx(rate_rx),
    .viol_any(viol_any));
`default_nettype wire

// ---- tb/prfr_card_model.sv ----
// Card-side model: carrier clock and character receiver
`timescale 1ns/1ps
`default_nettype none
module prfr_card_model #(
    parameter int TICKS_BASE = 8
)(
    output logic             lclk,
    input  wire logic        tx_out,
    input  wire logic [1:0]  rate,
    output logic             rx_stb,
    output logic [8:0]       rx_char
);
    int         w;
    int         k;
    logic [8:0] c;
    // Carrier-derived, so it runs between frames as well
    initial lclk = 1'b0;
    always #32 lclk = ~lclk;
    initial rx_stb = 1'b0;
    initial rx_char = 9'h000;
    ////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling: a character sent at another rate decodes wrongly
    always
    begin
        @(negedge tx_out);
        w = (TICKS_BASE >> rate) * 64;
        #(w / 2);
        for (k = 0; k < 9; k++)
        begin
            #(w);
            c[k] = tx_out;
        end
        rx_char = c;
        rx_stb = 1'b1;
        #1;
        rx_stb = 1'b0;
    end
endmodule // prfr_card_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the proximity reader framer
`timescale 1ns/1ps
`default_nettype none
`include "prfr_defines.svh"
module testbench;
    logic        pclk = 1'b0;
    logic        presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        lclk, tx_out, tx_active, viol_any, rx_stb;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  rate_tx, rate_rx, rate_exp;
    logic [8:0]  rx_char;
    logic [7:0]  fb [0:8];
    logic [65:0] rdq [$];
    logic [65:0] r;
    logic [8:0]  txq [$];
    logic [23:0] tbl [0:12];
    logic [27:0] blk [0:8];
    int          num_errors = 0;
    int          n_compared = 0;
    int          seed, i, j;
    always #4 pclk = ~pclk;
    prfr_framer #(.ADDR_W(8), .TICKS_BASE(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lclk_pin(lclk), .tx_out(tx_out), .tx_active(tx_active),
        .rate_tx(rate_tx), .rate_rx(rate_rx), .viol_any(viol_any));
    prfr_card_model #(.TICKS_BASE(8)) card_u (.lclk(lclk),
        .tx_out(tx_out), .rate(rate_exp), .rx_stb(rx_stb),
        .rx_char(rx_char));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [32:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic give_up;
        num_errors++;
        stop_test();
    endtask
    // Reads note {expected, mask}; the watcher below does the compare
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [32:0] e = 33'h0, m = 33'h0,
        input bit stall = 1'b0);
        int n;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        if (!wr)
            rdq.push_back({e & m, m});
        @(posedge pclk);
        penable <= 1'b1;
        ce <= !stall;
        for (n = 0; n < 3000; n++)
        begin
            @(posedge pclk);
            ce <= 1'b1;
            if (pready === 1'b1)
                break;
        end
        if (n == 3000)
            give_up();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic stat(input logic [15:0] e, m);
        apb(1'b0, `PRFR_OFF_STATUS, 32'h0, {17'h0, e}, {17'h0, m});
    endtask
    task automatic send(input int len);
        int k;
        int n;
        for (k = 0; k < len; k++)
        begin
            txq.push_back({1'b1, fb[k]});
            apb(1'b1, `PRFR_OFF_TXDATA, {23'h0, k == len - 1, fb[k]});
        end
        for (n = 0; n < 4000 && tx_active !== 1'b0; n++)
            @(posedge pclk);
        if (n == 4000)
            give_up();
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
        begin
            r = rdq.pop_front();
            check("read", {pslverr, prdata} & r[32:0], r[65:33]);
        end
    always @(posedge rx_stb)
        check("char", {24'h0, rx_char}, {24'h0, txq.pop_front()});
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rate_exp = 2'h0;
        seed = $urandom(32'hbefa);
        tbl = '{24'h120000, 24'h122002, 24'h120504, 24'h120604,
                24'h120704, 24'h250102, 24'h25c004, 24'h253004,
                24'h260904, 24'h270802, 24'h281002, 24'h280f04,
                24'h260800};
        blk = '{28'h025a200, 28'ha200208, 28'hf200110, 28'hf201200,
                28'ha200100, 28'h1600200, 28'h1700201, 28'h4200104,
                28'h0000120};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PRFR_OFF_CAP, 32'h0, {25'h0, `PRFR_CAP_RST},
            33'h1000000ff, 1'b1);
        stat(16'h0000, 16'hffff);
        apb(1'b0, 8'h10, 32'h0, 33'h100000000, 33'h1ffffffff);
        apb(1'b1, `PRFR_OFF_CAP, 32'h11);
        apb(1'b0, `PRFR_OFF_CAP, 32'h0, 33'h11, 33'h1000000ff);
        $display("test registers done");
        for (i = 0; i < 13; i++)
        begin
            fb[0] = (i < 5) ? `PRFR_CMD_REQB : `PRFR_CMD_ATTRIB;
            for (j = 1; j < 9; j++)
                fb[j] = 8'($urandom);
            fb[1] = (i < 5) ? 8'h00 : fb[1];
            fb[2] = 8'($urandom % 5);
            fb[5] = 8'h00;
            fb[6] = 8'h08;
            fb[7] = 8'h00;
            fb[8] = 8'h0e;
            if (i > 0)
                fb[tbl[i][19:16]] = tbl[i][15:8];
            apb(1'b1, `PRFR_OFF_CTRL, {29'h0, tbl[i][22:20]});
            send((i < 5) ? 3 : 9);
            stat({8'h0, tbl[i][7:0]}, 16'h00ff);
            apb(1'b1, `PRFR_OFF_STATUS, 32'hff);
            stat(16'h0000, 16'h00ff);
        end
        $display("test request fields done");
        apb(1'b1, `PRFR_OFF_CTRL, 32'h103);
        fb[0] = `PRFR_CMD_RATS;
        fb[1] = 8'h50;
        send(2);
        stat(16'h2000, 16'h70ff);
        apb(1'b1, `PRFR_OFF_CTRL, 32'h4);
        fb[0] = 8'hd0;
        fb[1] = 8'h11;
        fb[2] = 8'h05;
        send(3);
        stat(16'h3000, 16'h70ff);
        // Stands for the card's selection response
        apb(1'b1, `PRFR_OFF_CTRL, 32'h400);
        rate_exp <= 2'h1;
        stat(16'h4500, 16'h7fff);
        apb(1'b1, `PRFR_OFF_CTRL, 32'h0);
        for (i = 0; i < 9; i++)
        begin
            fb[0] = blk[i][27:20];
            fb[1] = blk[i][19:12];
            send(blk[i][11:8]);
            stat({8'h0, blk[i][7:0]}, 16'h00ff);
            apb(1'b1, `PRFR_OFF_STATUS, 32'hff);
        end
        apb(1'b1, `PRFR_OFF_CTRL, 32'h200);
        rate_exp <= 2'h0;
        stat(16'h0000, 16'h7fff);
        // Selection out of sequence and beyond the card's capability
        apb(1'b1, `PRFR_OFF_CTRL, 32'h4);
        fb[0] = 8'hd0;
        fb[1] = 8'h11;
        fb[2] = 8'h0f;
        send(3);
        stat(16'h00c0, 16'h70ff);
        $display("test session done");
        // A silent link must not pass: every noted result has to show up
        check("left", 33'(txq.size() + rdq.size()), 33'h0);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
